// ---- bst_pkg.sv ----
// Package for the boundary-scan test access port.
// Assumes a 20 MHz system clock and a test clock from an external tester.
package bst_pkg;

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    localparam int IR_LEN = 10;
    localparam logic [9:0] IR_SAMPLE = 10'h005;
    localparam logic [9:0] IR_EXTEST = 10'h00f;
    localparam logic [9:0] IR_BYPASS = 10'h3ff;
    localparam logic [9:0] IR_USERCODE = 10'h007;
    localparam logic [9:0] IR_IDCODE = 10'h006;
    localparam logic [9:0] IR_HIGHZ = 10'h00b;
    localparam logic [9:0] IR_CLAMP = 10'h00a;
    localparam logic [9:0] IR_USER_A = 10'h00c;
    localparam logic [9:0] IR_USER_B = 10'h00e;
    localparam logic [9:0] IR_CAPTURE_VAL = 10'h001;
    localparam logic [9:0] IR_RESET_VAL = IR_IDCODE;

    // ------------------------------------------------------------------
    // Identification and user code layout
    // ------------------------------------------------------------------
    localparam int ID_LEN = 32;
    localparam int ID_VER_POS = 28;
    localparam int ID_PART_POS = 12;
    localparam int ID_MFR_POS = 1;
    localparam logic [ID_LEN-1:0] USERCODE_RESET = 32'hffff_ffff;

    // ------------------------------------------------------------------
    // Boundary register layout: three cells per pin
    // ------------------------------------------------------------------
    localparam int BSR_LEN_DEFAULT = 240;
    localparam int CELLS_PER_PIN = 3;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // ------------------------------------------------------------------
    // Configuration wait after power-up
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONFIG_WAIT_NS = 500000;
    localparam int CONFIG_WAIT_CYC =
        (CONFIG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // TAP controller states
    typedef enum logic [3:0] {
        ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
        ST_SH_DR = 4'h6, ST_EX1_DR = 4'h7, ST_PAU_DR = 4'h5,
        ST_EX2_DR = 4'h4, ST_UPD_DR = 4'hc, ST_SEL_IR = 4'hd,
        ST_CAP_IR = 4'hf, ST_SH_IR = 4'he, ST_EX1_IR = 4'ha,
        ST_PAU_IR = 4'hb, ST_EX2_IR = 4'h9, ST_UPD_IR = 4'h8
    } bst_state_t;

endpackage

// ---- bst_tap.sv ----
// Test access port with instruction decode and data register routing.
// Assumes tck, tms and tdi come from an external tester and that the
// I/O pads take pin_out, pin_oe and keep enables from this block.
//
// Summary of operation
// - Ten-bit instruction register shifts on IR path.
// - Sample/preload captures pins, loads update pattern.
// - Extest drives boundary outputs, captures pin inputs.
// - Bypass inserts one-bit register, core keeps running.
// - Usercode shifts 32-bit code, default all ones.
// - Idcode shifts identification register out.
// - Highz routes bypass and floats every pin.
// - Clamp routes bypass, pins hold boundary levels.
// - Pull-up and bus-hold enables follow core_keep_en in every mode.
// - Two user codes each select own chain.
// - User chains see TAP pins and states.
// - Idcode fields: version, part, maker, one.
// - Boundary register length is a parameter.
// - Extra programming instructions accepted through port.
`timescale 1ns/1ps
`default_nettype none
module bst_tap
    import bst_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_DEFAULT,
    parameter int CFG_WAIT_CYC = CONFIG_WAIT_CYC,
    parameter logic [3:0] ID_VERSION = 4'h1,       // Arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234,     // Arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h155,     // Arbitrary value
    parameter logic [31:0] USERCODE = USERCODE_RESET,
    localparam int NPIN = BSR_LEN / CELLS_PER_PIN
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    output logic tap_ready,
    input wire logic [NPIN-1:0] core_out,
    input wire logic [NPIN-1:0] core_oe,
    input wire logic [NPIN-1:0] core_keep_en,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    output logic [NPIN-1:0] pin_keep_en,
    output logic isc_instr,
    output logic usr_tck,
    output logic usr_tms,
    output logic usr_tdi,
    output logic usr_sel_a,
    output logic usr_sel_b,
    output logic usr_capture,
    output logic usr_shift,
    output logic usr_update,
    output logic usr_tlr,
    output bst_state_t usr_state,
    input wire logic usr_tdo_a,
    input wire logic usr_tdo_b,
    output logic usr_update_evt
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // length per variant
    if (BSR_LEN % CELLS_PER_PIN != 0 || BSR_LEN < CELLS_PER_PIN) begin : g_bad
        $error("Boundary length must be a positive multiple of three");
    end
    if (CFG_WAIT_CYC < 1) begin : g_bad_wait
        $error("Configuration wait must be at least one cycle");
    end

    // ------------------------------------------------------------------
    // System clock side: configuration wait and user event
    // ------------------------------------------------------------------
    logic [31:0] wait_cnt_r, wait_cnt_nxt;
    logic ready_r, ready_nxt;
    logic evt_s1_r, evt_s2_r, evt_s3_r;
    logic usr_tgl_r, usr_tgl_nxt;

    // Count the wait after reset, then open the port
    always_comb begin
        wait_cnt_nxt = wait_cnt_r;
        ready_nxt = ready_r;
        if (!ready_r) begin
            if (wait_cnt_r == 32'(CFG_WAIT_CYC - 1)) begin
                ready_nxt = 1'b1;
            end else begin
                wait_cnt_nxt = wait_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Register the wait and resynchronise the user update toggle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wait_cnt_r <= 32'h0000_0000;
            ready_r <= 1'b0;
            evt_s1_r <= 1'b0;
            evt_s2_r <= 1'b0;
            evt_s3_r <= 1'b0;
        end else begin
            wait_cnt_r <= wait_cnt_nxt;
            ready_r <= ready_nxt;
            evt_s1_r <= usr_tgl_r;
            evt_s2_r <= evt_s1_r;
            evt_s3_r <= evt_s2_r;
        end
    end

    assign tap_ready = ready_r;
    assign usr_update_evt = evt_s2_r ^ evt_s3_r;

    // ------------------------------------------------------------------
    // Test clock side: crossings into tck
    // ------------------------------------------------------------------
    logic rdy_s1_r, rdy_s2_r;
    logic [NPIN-1:0] pin_s1_r, pin_s2_r;
    logic [NPIN-1:0] cout_s1_r, cout_s2_r, coe_s1_r, coe_s2_r;
    logic rst_tck_n;

    // Reset synchroniser: clears at once, releases two test clocks later
    always_ff @(posedge tck or negedge ready_r) begin
        if (!ready_r) begin
            rdy_s1_r <= 1'b0;
            rdy_s2_r <= 1'b0;
        end else begin
            rdy_s1_r <= 1'b1;
            rdy_s2_r <= rdy_s1_r;
        end
    end

    // Two-flop synchronisers for the pin and core levels
    always_ff @(posedge tck) begin
        pin_s1_r <= pin_in;
        pin_s2_r <= pin_s1_r;
        cout_s1_r <= core_out;
        cout_s2_r <= cout_s1_r;
        coe_s1_r <= core_oe;
        coe_s2_r <= coe_s1_r;
    end

    assign rst_tck_n = rdy_s2_r;

    // ------------------------------------------------------------------
    // TAP state machine and data registers
    // ------------------------------------------------------------------
    bst_state_t st_r, st_nxt;
    logic [IR_LEN-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
    logic byp_r, byp_nxt;
    logic [ID_LEN-1:0] id_sh_r, id_sh_nxt;
    logic [BSR_LEN-1:0] bsr_sh_r, bsr_sh_nxt, bsr_upd_r, bsr_upd_nxt;
    logic [BSR_LEN-1:0] cap_vec;
    logic [ID_LEN-1:0] id_val;
    logic sel_bsr, sel_id, sel_uc, sel_ua, sel_ub, sel_byp;
    logic drive_bsr, float_pins;

    assign id_val = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // Instruction decode; unlisted codes fall to bypass
    always_comb begin
        sel_bsr = (ir_r == IR_SAMPLE) || (ir_r == IR_EXTEST);
        sel_id = (ir_r == IR_IDCODE);
        sel_uc = (ir_r == IR_USERCODE);
        sel_ua = (ir_r == IR_USER_A);
        sel_ub = (ir_r == IR_USER_B);
        sel_byp = !(sel_bsr || sel_id || sel_uc || sel_ua || sel_ub);
        drive_bsr = (ir_r == IR_EXTEST) || (ir_r == IR_CLAMP);
        float_pins = (ir_r == IR_HIGHZ);
        isc_instr = sel_byp && (ir_r != IR_BYPASS) && !drive_bsr
            && !float_pins;
    end

    // Next state and register contents
    always_comb begin
        st_nxt = st_r;
        ir_sh_nxt = ir_sh_r;
        ir_nxt = ir_r;
        byp_nxt = byp_r;
        id_sh_nxt = id_sh_r;
        bsr_sh_nxt = bsr_sh_r;
        bsr_upd_nxt = bsr_upd_r;
        usr_tgl_nxt = usr_tgl_r;
        case (st_r)
            ST_TLR: st_nxt = tms ? ST_TLR : ST_RTI;
            ST_RTI: st_nxt = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: st_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: st_nxt = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: st_nxt = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: st_nxt = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: st_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: st_nxt = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: st_nxt = tms ? ST_SEL_DR : ST_RTI;
            default: st_nxt = ST_TLR;
        endcase
        if (st_r == ST_TLR) begin
            ir_nxt = IR_RESET_VAL;
        end
        if (st_r == ST_CAP_IR) begin
            ir_sh_nxt = IR_CAPTURE_VAL;
        end
        if (st_r == ST_SH_IR) begin
            ir_sh_nxt = {tdi, ir_sh_r[IR_LEN-1:1]};
        end
        if (st_r == ST_UPD_IR) begin
            ir_nxt = ir_sh_r;
        end
        if (st_r == ST_CAP_DR && sel_byp) begin
            byp_nxt = 1'b0;
        end
        if (st_r == ST_SH_DR && sel_byp) begin
            byp_nxt = tdi;
        end
        if (st_r == ST_CAP_DR && sel_uc) begin
            id_sh_nxt = USERCODE;
        end
        if (st_r == ST_CAP_DR && sel_id) begin
            id_sh_nxt = id_val;
        end
        if (st_r == ST_SH_DR && (sel_id || sel_uc)) begin
            id_sh_nxt = {tdi, id_sh_r[ID_LEN-1:1]};
        end
        if (st_r == ST_CAP_DR && sel_bsr) begin
            bsr_sh_nxt = cap_vec;
        end
        if (st_r == ST_SH_DR && sel_bsr) begin
            bsr_sh_nxt = {tdi, bsr_sh_r[BSR_LEN-1:1]};
        end
        if (st_r == ST_UPD_DR && sel_bsr) begin
            bsr_upd_nxt = bsr_sh_r;
        end
        if (st_r == ST_UPD_DR && (sel_ua || sel_ub)) begin
            usr_tgl_nxt = !usr_tgl_r;
        end
    end

    // Register the test clock state; held reset while the port is closed
    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            st_r <= ST_TLR;
            ir_sh_r <= IR_CAPTURE_VAL;
            ir_r <= IR_RESET_VAL;
            byp_r <= 1'b0;
            id_sh_r <= {ID_LEN{1'b0}};
            bsr_sh_r <= {BSR_LEN{1'b0}};
            bsr_upd_r <= {BSR_LEN{1'b0}};
            usr_tgl_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r <= ir_nxt;
            byp_r <= byp_nxt;
            id_sh_r <= id_sh_nxt;
            bsr_sh_r <= bsr_sh_nxt;
            bsr_upd_r <= bsr_upd_nxt;
            usr_tgl_r <= usr_tgl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Boundary cells and pin control, one set per pin
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        assign cap_vec[CELLS_PER_PIN*i+CELL_IN] = pin_s2_r[i];
        assign cap_vec[CELLS_PER_PIN*i+CELL_OUT] = cout_s2_r[i];
        assign cap_vec[CELLS_PER_PIN*i+CELL_OE] = coe_s2_r[i];

        always_comb begin
            if (drive_bsr) begin
                pin_out[i] = bsr_upd_r[CELLS_PER_PIN*i+CELL_OUT];
                pin_oe[i] = bsr_upd_r[CELLS_PER_PIN*i+CELL_OE];
            end else begin
                pin_out[i] = core_out[i];
                pin_oe[i] = float_pins ? 1'b0 : core_oe[i];
            end
        end

        assign pin_keep_en[i] = core_keep_en[i];
    end

    // ------------------------------------------------------------------
    // User chain access
    // ------------------------------------------------------------------
    // two separate user chains
    assign usr_sel_a = sel_ua;
    assign usr_sel_b = sel_ub;
    assign usr_tck = tck;
    assign usr_tms = tms;
    assign usr_tdi = tdi;
    assign usr_state = st_r;
    assign usr_capture = (st_r == ST_CAP_DR);
    assign usr_shift = (st_r == ST_SH_DR);
    assign usr_update = (st_r == ST_UPD_DR);
    assign usr_tlr = (st_r == ST_TLR);

    // ------------------------------------------------------------------
    // Serial output on the falling edge
    // ------------------------------------------------------------------
    logic tdo_nxt, tdo_oe_nxt, tdo_r, tdo_oe_r;

    // Select the bit that leaves the active register
    always_comb begin
        tdo_oe_nxt = (st_r == ST_SH_IR) || (st_r == ST_SH_DR);
        if (st_r == ST_SH_IR) begin
            tdo_nxt = ir_sh_r[0];
        end else if (sel_bsr) begin
            tdo_nxt = bsr_sh_r[0];
        end else if (sel_id || sel_uc) begin
            tdo_nxt = id_sh_r[0];
        end else if (sel_ua) begin
            tdo_nxt = usr_tdo_a;
        end else if (sel_ub) begin
            tdo_nxt = usr_tdo_b;
        end else begin
            tdo_nxt = byp_r;
        end
    end

    always_ff @(negedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_five_ones;
        tms [*5];
    endsequence

    sequence s_cap_dr(logic sel);
        st_r == ST_CAP_DR && sel;
    endsequence

    a_tlr_five_ones: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        s_five_ones |=> st_r == ST_TLR)
        else $error("Five TMS ones did not reach reset state");

    a_ir_update_load: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        st_r == ST_UPD_IR |=> ir_r == $past(ir_sh_r))
        else $error("Instruction not applied at update");

    a_bypass_capture: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        s_cap_dr(sel_byp) |=> byp_r == 1'b0)
        else $error("Bypass bit not cleared at capture");

    a_usercode_load: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        s_cap_dr(sel_uc) |=> id_sh_r == USERCODE)
        else $error("User code not captured");

    a_idcode_load: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        s_cap_dr(sel_id) |=> id_sh_r == id_val && id_sh_r[0])
        else $error("Identification code not captured");

    a_preload_update: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        st_r == ST_UPD_DR && sel_bsr |=> bsr_upd_r == $past(bsr_sh_r))
        else $error("Preload pattern not updated");

    a_highz_float: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        ir_r == IR_HIGHZ |-> pin_oe == {NPIN{1'b0}} && sel_byp)
        else $error("Pins driven while floated");

    a_clamp_hold: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        ir_r == IR_CLAMP |-> pin_out[0] == bsr_upd_r[CELL_OUT]
            && pin_oe[0] == bsr_upd_r[CELL_OE] && sel_byp)
        else $error("Clamped pin does not follow boundary cell");

    a_user_chain_tdo: assert property (
        @(posedge tck) disable iff (!rst_tck_n)
        st_r == ST_SH_DR && sel_ua && !tms ##1 1 |-> tdo_nxt == usr_tdo_a)
        else $error("User chain A not routed to output");

    a_wait_ready: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(ready_r) |-> $past(wait_cnt_r) == 32'(CFG_WAIT_CYC - 1))
        else $error("Port opened before configuration wait");

endmodule
`default_nettype wire

// ---- bst_ctl_model.sv ----
// Behavioural tester that drives the test access port pins.
// Assumes the device raises tap_ready once it may be scanned.
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo,
    input wire logic tap_ready,
    output var logic res_stb,
    output var logic [31:0] res_data
);
    // ----------------------------------------------------------------
    // Idle levels; the test clock stands still between frames
    // ----------------------------------------------------------------
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        res_stb = 1'b0;
        res_data = '0;
    end

    // rising edge sampling
    // One test clock period: drive, rise and sample, fall
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3 tck = 1'b1;
        q = tdo;
        #3 tck = 1'b0;
    endtask

    // wait before scanning
    // Stay in reset state until ready, then settle in idle
    task automatic start();
        logic q;
        wait (tap_ready === 1'b1);
        for (int i = 0; i < 6; i++) begin
            pulse(i < 5, 1'b0, q);
        end
    endtask

    // erase and program pulses
    // Idle in run-test-idle for a pulse time scaled to test clocks
    task automatic idle(input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            pulse(1'b0, tdi, q);
        end
    endtask

    // lsb first shifting
    // Instruction or data scan from idle back to idle
    task automatic scan(input bit ir, input int len, input logic [31:0] din);
        int pre;
        logic [63:0] tm;
        logic [63:0] ti;
        logic [63:0] to;
        pre = ir ? 4 : 3;
        tm = ir ? 64'h3 : 64'h1;
        tm = tm | (64'h3 << (pre + len - 1));
        ti = {32'h0, din} << pre;
        to = '0;
        for (int i = 0; i < pre + len + 2; i++) begin
            pulse(tm[i], ti[i], to[i]);
        end
        tdi = ~tdi;  // Released line shows no stale value
        res_data = 32'(to >> pre);
        res_stb = 1'b1;
        #1 res_stb = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the boundary-scan port.
// Assumes the tester model drives the test pins; bench drives core side.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bst_pkg::*;
    localparam int BSR = 6;
    localparam int NP = BSR / CELLS_PER_PIN;
    localparam logic [3:0] VER = 4'h2;       // Arbitrary value
    localparam logic [15:0] PART = 16'h5a3c; // Arbitrary value
    localparam logic [10:0] MAKER = 11'h2b7; // Arbitrary value
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, tap_ready, isc_instr;
    logic [NP-1:0] core_out = '0;
    logic [NP-1:0] core_oe = '0;
    logic [NP-1:0] core_keep_en = '0;
    logic [NP-1:0] pin_in = '0;
    localparam logic [31:0] EVT_MARK = 32'h0000_0e7e;
    logic [NP-1:0] pin_out, pin_oe, pin_keep_en;
    logic usr_update_evt;
    bst_state_t usr_state;
    logic usr_sel_a, usr_sel_b, res_stb, pin_stb = 1'b0;
    logic usr_tdo_a = 1'b0;
    logic usr_tdo_b = 1'b0;
    logic [31:0] res_data, got, ev, mv;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    int seed = 71;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    // ----------------------------------------------------------------
    // Clock, timeout and instances
    // ----------------------------------------------------------------
    always #25 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    bst_tap #(.BSR_LEN(BSR), .CFG_WAIT_CYC(4), .ID_VERSION(VER),
        .ID_PART(PART), .ID_MAKER(MAKER)) bst_tap_i (
        .clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .tap_ready(tap_ready),
        .core_out(core_out), .core_oe(core_oe),
        .core_keep_en(core_keep_en), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_keep_en(pin_keep_en),
        .isc_instr(isc_instr), .usr_tck(), .usr_tms(), .usr_tdi(),
        .usr_sel_a(usr_sel_a), .usr_sel_b(usr_sel_b), .usr_capture(),
        .usr_shift(), .usr_update(), .usr_tlr(), .usr_state(usr_state),
        .usr_tdo_a(usr_tdo_a), .usr_tdo_b(usr_tdo_b),
        .usr_update_evt(usr_update_evt));

    bst_ctl_model bst_ctl_model_i (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tap_ready(tap_ready), .res_stb(res_stb), .res_data(res_data));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("Error at %0t: expected %h got %h", $time, 32'h0,
                exp_q.size());
        end
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic note(input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        mask_q.push_back(m);
    endtask

    function automatic logic [31:0] pv(input logic [2:0] f,
        input logic [NP-1:0] k, input logic [NP-1:0] oe,
        input logic [NP-1:0] o);
        return 32'({f, k, oe, o});
    endfunction

    // Snapshot of the pin side and instruction flags
    task automatic probe(input logic [31:0] e, input logic [31:0] m);
        note(e | 32'(ST_RTI) << 10, m | 32'h3e00);
        @(posedge clk) pin_stb <= 1'b1;
        @(posedge clk) pin_stb <= 1'b0;
    endtask

    task automatic ir(input logic [9:0] c);
        note(32'h001, 32'h3ff);
        bst_ctl_model_i.scan(1'b1, IR_LEN, 32'(c));
    endtask

    task automatic byp_check(input logic [9:0] c, input logic [31:0] e,
        input logic [31:0] m);
        logic [31:0] d;
        d = $random(seed);
        ir(c);
        note({30'h0, d[0], 1'b0}, 32'h3);
        bst_ctl_model_i.scan(1'b0, 2, d);
        probe(e, m);
    endtask

    // Watcher: each result takes the oldest note
    always @(posedge res_stb or posedge pin_stb
        or posedge usr_update_evt) begin
        got = res_stb ? res_data
            : pin_stb ? 32'({usr_state, tdo_oe, isc_instr, usr_sel_b,
                usr_sel_a, pin_keep_en, pin_oe, pin_out})
            : EVT_MARK;
        ev = exp_q.pop_front();
        mv = mask_q.pop_front();
        n_tests++;
        if ((got & mv) !== (ev & mv)) begin
            bad_count++;
            $display("Error at %0t: expected %h got %h", $time, ev & mv,
                got & mv);
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] e;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        core_out <= NP'($random(seed));
        core_oe <= NP'($random(seed));
        core_keep_en <= NP'($random(seed));
        pin_in <= NP'($random(seed));
        d = $random(seed);
        usr_tdo_a <= d[0];
        usr_tdo_b <= ~d[0];
        bst_ctl_model_i.start();
        note(32'({VER, PART, MAKER, 1'b1}), '1);
        bst_ctl_model_i.scan(1'b0, ID_LEN, d);
        ir(IR_USERCODE);
        note(USERCODE_RESET, '1);
        bst_ctl_model_i.scan(1'b0, ID_LEN, d);
        byp_check(IR_BYPASS, pv(3'b000, core_keep_en, core_oe, core_out),
            32'h1ff);
        byp_check(IR_HIGHZ, pv(3'b000, core_keep_en, '0, '0),
            32'h1fc);
        byp_check(10'h0f0, pv(3'b100, core_keep_en, '0, '0),
            32'h1f0);
        bst_ctl_model_i.idle(75);
        ir(IR_SAMPLE);
        probe(pv(3'b000, core_keep_en, core_oe, core_out), 32'h1ff);
        d = $random(seed);
        note(32'({core_oe[1], core_out[1], pin_in[1], core_oe[0],
            core_out[0], pin_in[0]}), 32'h3f);
        bst_ctl_model_i.scan(1'b0, BSR, d);
        @(posedge clk) pin_in <= ~pin_in;
        ir(IR_EXTEST);
        probe(pv(3'b000, core_keep_en, {d[5], d[2]}, {d[4], d[1]}),
            32'h1ff);
        e = $random(seed);
        note(32'({core_oe[1], core_out[1], pin_in[1], core_oe[0],
            core_out[0], pin_in[0]}), 32'h3f);
        bst_ctl_model_i.scan(1'b0, BSR, e);
        byp_check(IR_CLAMP, pv(3'b000, core_keep_en, {e[5], e[2]},
            {e[4], e[1]}), 32'h1ff);
        ir(IR_USER_A);
        probe(32'h040, 32'h1c0);
        note({32{usr_tdo_a}}, 32'hff);
        note(EVT_MARK, '1);
        bst_ctl_model_i.scan(1'b0, 8, d);
        repeat (4) @(posedge clk);
        ir(IR_USER_B);
        probe(32'h080, 32'h1c0);
        note({32{usr_tdo_b}}, 32'hff);
        note(EVT_MARK, '1);
        bst_ctl_model_i.scan(1'b0, 8, d);
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
